// ==== rtl/cec_tx.sv ====
`timescale 1ns/100ps
module cec_tx
    import cec_tx_pkg::*;
#(
    parameter int unsigned MAX_BYTES = 16
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // bus line, open drain
    input wire logic cec_line_i,
    output logic cec_line_o,
    output logic cec_line_oe_o,
    // idle interval from signal free time manager
    input wire logic idle_done_i,
    output logic tx_done_o
);
    typedef enum {
        ST_IDLE, ST_SLOW, ST_SREL, ST_SREST, ST_BLOW, ST_BREL, ST_BRECHK,
        ST_BREST, ST_PAUSE, ST_ALOST
    } state_t;
    state_t st_q, st_d;
    logic [CNT_W-1:0] tmr_q, tmr_d;
    logic [1:0] req_q, req_d;
    logic [3:0] status_q, status_d, ws_q, ws_d;
    logic [3:0] retry_max_q, retry_max_d, tries_q, tries_d;
    logic [7:0] lat_q, lat_d, byte_q, byte_d, data_q, data_d;
    logic bcast_q, bcast_d, eom_q, eom_d;
    logic [3:0] bit_q, bit_d;
    logic drive_q, drive_d, done_q, done_d;
    logic [2:0] sync_q;
    logic line_q, line_d;
    // bus slave state
    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic smp, tmr_end, cur_bit, is_ack;
    logic [CNT_W-1:0] lat_ext;
    assign smp = line_q;
    assign tmr_end = (tmr_q == '0);
    assign lat_ext = CNT_W'(lat_q);
    assign is_ack = (bit_q == 4'h9);
    assign cur_bit = (bit_q < 4'h8) ? data_q[3'(4'h7 - bit_q)]
                   : (bit_q == 4'h8) ? eom_q : 1'b1;
    function automatic logic [CNT_W-1:0] ld(input logic [CNT_W-1:0] c,
                                            input logic [CNT_W-1:0] l);
        ld = (c > l + CNT_W'(1)) ? c - l - CNT_W'(1) : '0;
    endfunction : ld
    // three-flop input sync, change when 2nd and 3rd agree
    always_comb begin
        line_d = line_q;
        if (sync_q[2] == sync_q[1]) begin
            line_d = sync_q[2];
        end
    end
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_end ? tmr_q : tmr_q - CNT_W'(1);
        req_d = req_q;
        status_d = status_q;
        tries_d = tries_q;
        byte_d = byte_q;
        bit_d = bit_q;
        drive_d = drive_q;
        done_d = 1'b0;
        case (st_q)
            ST_IDLE: begin
                drive_d = 1'b0;
                if ((req_q == request_normal_send ||
                     req_q == request_address_allocation)
                    && idle_done_i) begin
                    drive_d = 1'b1;
                    tmr_d = ld(C_START_LOW, lat_ext);
                    byte_d = 8'h00;
                    bit_d = 4'h0;
                    status_d = STATUS_NONE;
                    st_d = ST_SLOW;
                end
            end
            ST_SLOW: if (tmr_end) begin
                drive_d = 1'b0;
                tmr_d = ld(C_START_SMP, lat_ext);
                st_d = ST_SREL;
            end
            ST_SREL: if (tmr_end) begin
                // no follower error check here
                if (smp) begin
                    tmr_d = ld(C_START_REST, lat_ext);
                    st_d = ST_SREST;
                end else begin
                    status_d = status_tx_arbitration_lost;
                    tmr_d = ld(C_ALOST, lat_ext);
                    st_d = ST_ALOST;
                end
            end
            ST_SREST, ST_BREST: if (tmr_end) begin
                drive_d = 1'b1;
                tmr_d = ld(cur_bit ? C_ONE_LOW : C_ZERO_LOW, lat_ext);
                st_d = ST_BLOW;
            end
            ST_BLOW: if (tmr_end) begin
                drive_d = 1'b0;
                tmr_d = ld(C_BIT_SMP, lat_ext);
                st_d = ST_BREL;
            end
            ST_BREL: if (tmr_end) begin
                if (is_ack) begin
                    if (smp != bcast_q) begin
                        status_d = status_tx_no_acknowledge;
                        tmr_d = C_RETRY_PAUSE;
                        st_d = ST_PAUSE;
                    end else if (eom_q) begin
                        req_d = REQ_NONE;
                        done_d = 1'b1;
                        tries_d = 4'h0;
                        st_d = ST_IDLE;
                    end else begin
                        byte_d = byte_q + 8'h01;
                        bit_d = 4'h0;
                        tmr_d = ld(C_BIT - C_ONE_LOW - C_BIT_SMP, lat_ext);
                        st_d = ST_BREST;
                    end
                end else if (smp) begin
                    bit_d = bit_q + 4'h1;
                    tmr_d = ld(C_BIT - (cur_bit ? C_ONE_LOW : C_ZERO_LOW)
                               - C_BIT_SMP, lat_ext);
                    st_d = ST_BREST;
                end else if (!cur_bit) begin
                    status_d = status_tx_low_on_release;
                    tmr_d = C_RETRY_PAUSE;
                    st_d = ST_PAUSE;
                end else begin
                    tmr_d = ld(C_ONE_RECHK, lat_ext);
                    st_d = ST_BRECHK;
                end
            end
            ST_BRECHK: if (tmr_end) begin
                if (smp && byte_q == 8'h00 && bit_q < 4'h4) begin
                    status_d = status_tx_arbitration_lost;
                    tmr_d = ld(C_ALOST, lat_ext);
                    st_d = ST_ALOST;
                end else begin
                    status_d = smp ? status_tx_bit_failure
                                   : status_tx_low_on_release;
                    tmr_d = C_RETRY_PAUSE;
                    st_d = ST_PAUSE;
                end
            end
            ST_PAUSE: if (tmr_end) begin
                if (tries_q >= retry_max_q) begin
                    status_d = status_tx_attempts_exhausted;
                    req_d = REQ_NONE;
                    tries_d = 4'h0;
                    st_d = ST_IDLE;
                end else begin
                    tries_d = tries_q + 4'h1;
                    st_d = ST_IDLE;
                end
            end
            ST_ALOST: if (tmr_end) begin
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // axi4-lite slave
    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        retry_max_d = retry_max_q;
        lat_d = lat_q;
        data_d = data_q;
        bcast_d = bcast_q;
        eom_d = eom_q;
        if (s_axi_awvalid_i && !aw_q) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_q) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata_i;
            ws_d = s_axi_wstrb_i;
        end
        if (aw_q && w_q && !bv_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = RESP_OKAY;
            if (awa_q == REG_RETRY) begin
                retry_max_d = wd_q[3:0];
            end else if (awa_q == REG_LAT) begin
                lat_d = wd_q[7:0];
            end else if (awa_q == REG_DATA) begin
                data_d = wd_q[7:0];
                eom_d = wd_q[8];
                bcast_d = wd_q[9];
            end else if (awa_q != REG_CTRL && awa_q != REG_RXERR) begin
                br_d = RESP_SLVERR;
            end
        end else if (bv_q && s_axi_bready_i) begin
            bv_d = 1'b0;
        end
        if (s_axi_arvalid_i && !rv_q) begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            rd_d = 32'h0000_0000;
            if (s_axi_araddr_i == REG_CTRL) begin
                rd_d = {30'h0, req_q};
            end else if (s_axi_araddr_i == REG_STATUS) begin
                rd_d = {27'h0, st_q != ST_IDLE, status_q};
            end else if (s_axi_araddr_i == REG_DATA) begin
                rd_d = {22'h0, bcast_q, eom_q, data_q};
            end else if (s_axi_araddr_i == REG_RETRY) begin
                rd_d = {28'h0, retry_max_q};
            end else if (s_axi_araddr_i == REG_LAT) begin
                rd_d = {24'h0, lat_q};
            end else begin
                rr_d = RESP_SLVERR;
            end
        end else if (rv_q && s_axi_rready_i) begin
            rv_d = 1'b0;
        end
    end

    // request and receive-error writes merge into fsm next values
    logic [1:0] req_m;
    logic [3:0] status_m;
    always_comb begin
        req_m = req_d;
        status_m = status_d;
        if (aw_q && w_q && !bv_q && awa_q == REG_CTRL && req_q == REQ_NONE
            && ws_q != 4'h0) begin
            req_m = wd_q[1:0];
        end
        if (aw_q && w_q && !bv_q && awa_q == REG_RXERR && st_q == ST_IDLE
            && wd_q[3:0] >= status_rx_start_timing
            && wd_q[3:0] <= status_rx_length_overflow) begin
            status_m = wd_q[3:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= ST_IDLE;
            tmr_q <= '0;
            req_q <= REQ_NONE;
            status_q <= STATUS_NONE;
            retry_max_q <= RETRY_RST;
            tries_q <= 4'h0;
            lat_q <= LAT_RST;
            byte_q <= 8'h00;
            data_q <= 8'h00;
            bcast_q <= 1'b0;
            eom_q <= 1'b0;
            bit_q <= 4'h0;
            drive_q <= 1'b0;
            done_q <= 1'b0;
            sync_q <= 3'h7;
            line_q <= 1'b1;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            rd_q <= 32'h0000_0000;
            br_q <= RESP_OKAY;
            rr_q <= RESP_OKAY;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            req_q <= req_m;
            status_q <= status_m;
            retry_max_q <= retry_max_d;
            tries_q <= tries_d;
            lat_q <= lat_d;
            byte_q <= byte_d;
            data_q <= data_d;
            bcast_q <= bcast_d;
            eom_q <= eom_d;
            bit_q <= bit_d;
            drive_q <= drive_d;
            done_q <= done_d;
            sync_q <= {sync_q[1:0], cec_line_i};
            line_q <= line_d;
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            rd_q <= rd_d;
            br_q <= br_d;
            rr_q <= rr_d;
        end
    end
    assign cec_line_o = 1'b0;
    assign cec_line_oe_o = drive_q;
    assign tx_done_o = done_q;
    assign s_axi_awready_o = !aw_q;
    assign s_axi_wready_o = !w_q;
    assign s_axi_bvalid_o = bv_q;
    assign s_axi_bresp_o = br_q;
    assign s_axi_arready_o = !rv_q;
    assign s_axi_rvalid_o = rv_q;
    assign s_axi_rdata_o = rd_q;
    assign s_axi_rresp_o = rr_q;
endmodule : cec_tx

// ==== rtl/cec_tx_pkg.sv ====
// Contract
// - start a frame only for request code 1 (normal) or 2 (address allocation)
// - wait until idle interval since last frame has passed before start bit
// - on success clear request and pulse completion; accept next only after
// - resend failed frame up to max attempts, then report status code 2
// - transmit codes: 0 none, 1 no ack, 3 arbitration, 4 low seen, 5 bit
// - no ack on directed frame fails; ack on broadcast frame fails
// - receive codes: 6 start timing, 7 bit timing, 9 byte limit exceeded
// - code 8 when error-signalling low pulse is shorter than minimum
// - programmed intervals shortened by known service latency; the retry pause is loaded unshortened
// - after idle, pull line low for 3.7 ms as start bit
// - release line, sample 0.4 ms later, 0.2 ms past 3.9 ms limit
// - sampled high: start bit valid, continue after further 0.4 ms
// - sampled low: code 3, receive mode, time 1.9 ms
// - no low level treated as follower error during start bit
// - zero bit: 1.5 ms low, release, sample 0.45 ms later
// - one bit: 0.6 ms low, release; low sample resolved by one further sample 0.9 ms later
// - after follower error or bit error, retransmit after three bit periods
package cec_tx_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    // times in microseconds
    localparam int unsigned T_START_LOW_US = 3700;
    localparam int unsigned T_START_SMP_US = 400;
    localparam int unsigned T_START_REST_US = 400;
    localparam int unsigned T_ALOST_US = 1900;
    localparam int unsigned T_ZERO_LOW_US = 1500;
    localparam int unsigned T_ONE_LOW_US = 600;
    localparam int unsigned T_BIT_SMP_US = 450;
    localparam int unsigned T_ONE_RECHK_US = 900;
    localparam int unsigned T_BIT_US = 2400;
    localparam int unsigned T_ERR_LOW_MIN_US = 3400;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned CNT_W = 24;
    localparam logic [CNT_W-1:0] C_START_LOW =
        CNT_W'(T_START_LOW_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_START_SMP =
        CNT_W'(T_START_SMP_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_START_REST =
        CNT_W'(T_START_REST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_ALOST = CNT_W'(T_ALOST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_ZERO_LOW =
        CNT_W'(T_ZERO_LOW_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_ONE_LOW = CNT_W'(T_ONE_LOW_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_BIT_SMP = CNT_W'(T_BIT_SMP_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_ONE_RECHK =
        CNT_W'(T_ONE_RECHK_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_BIT = CNT_W'(T_BIT_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_RETRY_PAUSE =
        CNT_W'(3 * T_BIT_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] C_ERR_LOW_MIN =
        CNT_W'(T_ERR_LOW_MIN_US * CYC_PER_US);
    // request codes
    localparam logic [1:0] REQ_NONE = 2'h0;
    localparam logic [1:0] request_normal_send = 2'h1;
    localparam logic [1:0] request_address_allocation = 2'h2;
    // status codes
    localparam logic [3:0] STATUS_NONE = 4'h0;
    localparam logic [3:0] status_tx_no_acknowledge = 4'h1;
    localparam logic [3:0] status_tx_attempts_exhausted = 4'h2;
    localparam logic [3:0] status_tx_arbitration_lost = 4'h3;
    localparam logic [3:0] status_tx_low_on_release = 4'h4;
    localparam logic [3:0] status_tx_bit_failure = 4'h5;
    localparam logic [3:0] status_rx_start_timing = 4'h6;
    localparam logic [3:0] status_rx_bit_timing = 4'h7;
    localparam logic [3:0] status_rx_short_error_low = 4'h8;
    localparam logic [3:0] status_rx_length_overflow = 4'h9;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_RETRY = 8'h0c;
    localparam logic [7:0] REG_LAT = 8'h10;
    localparam logic [7:0] REG_RXERR = 8'h14;
    localparam logic [3:0] RETRY_RST = 4'h5;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cec_tx_pkg

// ==== dv/cec_tx_chk.sv ====
`timescale 1ns/100ps
module cec_tx_chk
    import cec_tx_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // bus handshakes
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    // line and status
    input wire logic cec_line_o,
    input wire logic cec_line_oe_o,
    input wire logic idle_done_i,
    input wire logic tx_done_o
);
    localparam int LONG = 20000;
    localparam int START_MIN = int'(C_START_LOW) - 255;
    localparam int START_MAX = int'(C_START_LOW) + 1;
    localparam int GAP_MIN = int'(C_START_SMP + C_START_REST) - 511;
    logic [CNT_W-1:0] hi_q, hi_d, lo_q, lo_d;
    logic start_q, start_d, post_q, post_d;

    // run lengths of the drive enable, start bit and the gap after it
    always_comb begin
        hi_d = cec_line_oe_o ? hi_q + 1'b1 : '0;
        lo_d = cec_line_oe_o ? '0 : ((&lo_q) ? lo_q : lo_q + 1'b1);
        start_d = cec_line_oe_o && (start_q || lo_q > LONG);
        post_d = cec_line_oe_o ? 1'b0 : (post_q || start_q);
    end
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hi_q <= '0;
            lo_q <= '1;
            start_q <= 1'b0;
            post_q <= 1'b0;
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
            start_q <= start_d;
            post_q <= post_d;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_line_low_only: assert property (cec_line_o == 1'b0)
        else $error("line output driven high");
    chk_start_after_idle: assert property (
        $rose(cec_line_oe_o) && lo_q > LONG |-> $past(idle_done_i))
        else $error("start bit before idle interval");
    chk_start_low_len: assert property (
        $fell(cec_line_oe_o) && start_q |-> hi_q >= START_MIN &&
        hi_q <= START_MAX)
        else $error("start bit low phase length wrong");
    chk_start_high_gap: assert property (
        $rose(cec_line_oe_o) && post_q |-> lo_q >= GAP_MIN)
        else $error("line driven too soon after start bit");
    chk_done_one_cycle: assert property (tx_done_o |=> !tx_done_o)
        else $error("completion pulse longer than one cycle");
    chk_done_line_free: assert property (
        tx_done_o |-> !cec_line_oe_o)
        else $error("completion while line driven");
    chk_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    chk_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    chk_read_answer: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |->
        !cec_line_oe_o && !tx_done_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
        else $error("outputs active in reset");

    cover property ($fell(cec_line_oe_o) && start_q);
    cover property ($rose(cec_line_oe_o) && post_q);
    cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule : cec_tx_chk

bind cec_tx cec_tx_chk cec_tx_chk_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
    .cec_line_o(cec_line_o), .cec_line_oe_o(cec_line_oe_o),
    .idle_done_i(idle_done_i), .tx_done_o(tx_done_o)
);

// ==== dv/cec_peer.sv ====
`timescale 1ns/100ps
module cec_peer (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // shared line and low time to add after a seen falling edge
    input wire logic line_i,
    input wire logic [15:0] hold_i,
    output logic peer_oe_o
);
    logic [15:0] cnt_q;
    logic line_q;

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= 16'h0;
            line_q <= 1'b1;
        end else begin
            line_q <= line_i;
            if (cnt_q != 16'h0) cnt_q <= cnt_q - 16'h1;
            else if (line_q && !line_i) cnt_q <= hold_i;
        end
    end
    assign peer_oe_o = (cnt_q != 16'h0);
endmodule : cec_peer

// ==== dv/cec_tx_tb.sv ====
`timescale 1ns/100ps
module cec_tx_tb
    import cec_tx_pkg::*;
;
    typedef struct {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [1:0] br;
        logic [7:0] ra;
        logic [31:0] mask;
        logic [31:0] rd;
        logic [1:0] rr;
    } row_t;
    row_t rows [8] = '{
        '{REG_RETRY, 32'h3, RESP_OKAY, REG_RETRY, 32'hf, 32'h3, RESP_OKAY},
        '{REG_LAT, 32'h10, RESP_OKAY, REG_LAT, 32'hff, 32'h10, RESP_OKAY},
        '{REG_LAT, 32'h0, RESP_OKAY, REG_LAT, 32'hff, 32'h0, RESP_OKAY},
        '{8'h20, 32'h1, RESP_SLVERR, 8'h20, 32'h0, 32'h0, RESP_SLVERR},
        '{REG_RXERR, 32'h6, RESP_OKAY, REG_STATUS, 32'hf, 32'h6, RESP_OKAY},
        '{REG_RXERR, 32'h7, RESP_OKAY, REG_STATUS, 32'hf, 32'h7, RESP_OKAY},
        '{REG_RXERR, 32'h8, RESP_OKAY, REG_STATUS, 32'hf, 32'h8, RESP_OKAY},
        '{REG_RXERR, 32'h9, RESP_OKAY, REG_STATUS, 32'hf, 32'h9, RESP_OKAY}
    };
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b0;
    logic [7:0] s_axi_awaddr_i = 8'h00;
    logic s_axi_awvalid_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0;
    logic [7:0] s_axi_araddr_i = 8'h00;
    logic s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0;
    logic idle_done_i = 1'b0;
    logic [15:0] hold = 16'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, cec_line_o, cec_line_oe_o, tx_done_o, peer_oe;
    logic cec_line;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, br, rr;
    logic [31:0] s_axi_rdata_o, rd;
    int failures = 0;
    int n_compared = 0;
    int n;

    always #50 sys_clk_i = ~sys_clk_i;
    // pull-up: the line is low only while some party drives it
    assign cec_line = ~((cec_line_oe_o & ~cec_line_o) | peer_oe);

    cec_tx cec_tx_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_awvalid_i(s_axi_awvalid_i),
        .s_axi_awready_o(s_axi_awready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
        .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .cec_line_i(cec_line),
        .cec_line_o(cec_line_o), .cec_line_oe_o(cec_line_oe_o),
        .idle_done_i(idle_done_i), .tx_done_o(tx_done_o)
    );
    cec_peer cec_peer_inst (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .line_i(cec_line),
        .hold_i(hold), .peer_oe_o(peer_oe)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        br = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        rd = s_axi_rdata_o;
        rr = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : axi_read

    task automatic count_oe(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge sys_clk_i);
            if (cec_line_oe_o !== 1'b0) n++;
        end
    endtask : count_oe

    task automatic run_len(input logic lvl);
        n = 0;
        while (cec_line_oe_o === lvl) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask : run_len

    task automatic reset_dut;
        sys_rst_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : reset_dut

    task automatic finish_test;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        reset_dut();
        foreach (rows[i]) begin
            axi_write(rows[i].wa, rows[i].wd);
            check({30'h0, br}, {30'h0, rows[i].br});
            axi_read(rows[i].ra);
            check(rd & rows[i].mask, rows[i].rd);
            check({30'h0, rr}, {30'h0, rows[i].rr});
        end
        $display("register table test done");
        reset_dut();
        axi_read(REG_STATUS);
        check(rd & 32'hf, {28'h0, STATUS_NONE});
        axi_read(REG_RETRY);
        check(rd & 32'hf, {28'h0, RETRY_RST});
        axi_read(REG_LAT);
        check(rd & 32'hff, {24'h0, LAT_RST});
        $display("reset value test done");
        axi_write(REG_DATA, 32'h155);
        axi_write(REG_CTRL, {30'h0, REQ_NONE});
        idle_done_i <= 1'b1;
        count_oe(500);
        check(n, 32'h0);
        idle_done_i <= 1'b0;
        axi_write(REG_CTRL, {30'h0, request_normal_send});
        count_oe(500);
        check(n, 32'h0);
        // peer stretches the low phase to the latest allowed end
        hold <= 16'h9858;
        idle_done_i <= 1'b1;
        run_len(1'b0);
        run_len(1'b1);
        hold <= 16'h0;
        check(n, C_START_LOW);
        run_len(1'b0);
        check(n, C_START_SMP + C_START_REST);
        axi_read(REG_STATUS);
        check(rd & 32'hf, {28'h0, STATUS_NONE});
        $display("start bit test done");
        idle_done_i <= 1'b0;
        reset_dut();
        axi_write(REG_LAT, 32'h10);
        axi_write(REG_DATA, 32'h155);
        axi_write(REG_CTRL, {30'h0, request_address_allocation});
        // peer still low at the sample point
        hold <= 16'hafc8;
        idle_done_i <= 1'b1;
        run_len(1'b0);
        run_len(1'b1);
        idle_done_i <= 1'b0;
        hold <= 16'h0;
        check(n, C_START_LOW - 24'h10);
        count_oe(6000);
        check(n, 32'h0);
        axi_read(REG_STATUS);
        check(rd & 32'hf, {28'h0, status_tx_arbitration_lost});
        $display("arbitration test done");
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge sys_clk_i);
        failures++;
        $display("unexpected at %0t: watchdog %h %h", $time, 1'b1, 1'b0);
        finish_test();
    end
endmodule : cec_tx_tb
